// *** core/sapc_pkg.sv ***
// package: register map, field positions, reset values, timing and state codes
// assumes a 20 MHz system clock and an 8-bit write / 16-bit read register port
`default_nettype none
package sapc_pkg;
	// register offsets on the local address port
	localparam int ADDR_W = 3;
	localparam logic [2:0] ADDR_MODE = 3'h0;
	localparam logic [2:0] ADDR_CHAN = 3'h1;
	localparam logic [2:0] ADDR_PFMODE = 3'h2;
	localparam logic [2:0] ADDR_THRESH = 3'h3;
	localparam logic [2:0] ADDR_RESULT = 3'h4;
	localparam logic [2:0] ADDR_STATUS = 3'h5;
	// field positions
	localparam int MODE_START_BIT = 7;
	localparam int MODE_RATE_LSB = 3;
	localparam int MODE_RATE_MSB = 5;
	localparam int MODE_REF_BIT = 0;
	localparam int CHAN_MSB = 2;
	localparam int PF_EN_BIT = 7;
	localparam int PF_POL_BIT = 6;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_REF_READY_BIT = 1;
	localparam int RESULT_SHIFT = 6;
	localparam int RESULT_TOP = 9;
	localparam int RESULT_CMP_LSB = 2;
	localparam logic [3:0] TOP_BIT_IDX = 4'h9;
	// values after reset
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [2:0] CHAN_RST = 3'h0;
	localparam logic [1:0] PFMODE_RST = 2'h0;
	localparam logic [7:0] THRESH_RST = 8'h00;
	localparam logic [15:0] RESULT_RST = 16'h0000;
	// reference settling time
	localparam int REF_SETTLE_US = 14;
	localparam int CLK_MHZ = 20;
	localparam int REF_SETTLE_CYC_I = REF_SETTLE_US * CLK_MHZ;
	localparam logic [8:0] REF_SETTLE_CYC = 9'(REF_SETTLE_CYC_I);
	// cycles per bit decision for each rate code; sampling takes two bit periods
	localparam logic [7:0] RATE_BIT_CYC [0:7] = '{8'h18, 8'h14, 8'h10, 8'h0c, 8'h0a, 8'h08, 8'h06, 8'h05};
	localparam int SAMPLE_BIT_PERIODS = 2;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SAMPLE = 3'b001,
		ST_TRIAL = 3'b010,
		ST_COMPARE = 3'b011,
		ST_DONE = 3'b100
	} sapc_state_t;
endpackage
`default_nettype wire

// *** core/sapc_step_if.sv ***
// interface: step commands from the sequencer to the approximation register
// assumes both ends share clk_sys_in
`default_nettype none
interface sapc_step_if;
	logic clear;
	logic set_trial;
	logic decide;
	logic cmp_high;
	logic [3:0] bit_idx;
	logic [9:0] approx;
	modport ctrl (output clear, output set_trial, output decide, output cmp_high, output bit_idx, input approx);
	modport approximation_register (input clear, input set_trial, input decide, input cmp_high, input bit_idx, output approx);
endinterface
`default_nettype wire

// *** core/sapc_approx.sv ***
// approximation register: sets the trial bit, then keeps or clears it
// assumes the sequencer issues one command per cycle, synchronous reset
`default_nettype none
module sapc_approx (
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	sapc_step_if.approximation_register step
);
	logic [9:0] approx_r;

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			approx_r <= 10'h000;
		end else if (step.clear) begin
			approx_r <= 10'h000;
		end else if (step.set_trial) begin
			approx_r[step.bit_idx] <= 1'b1;
		end else if (step.decide) begin
			approx_r[step.bit_idx] <= step.cmp_high;
		end
	end

	assign step.approx = approx_r;
endmodule // sapc_approx
`default_nettype wire

// *** core/sapc_control.sv ***
// top: register port, conversion sequencer, result latch, end-of-conversion pulse
// assumes an external comparator answering the trial code on adc_tap_out
`default_nettype none
module sapc_control (
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	input wire logic [2:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [15:0] reg_rdata_out,
	input wire logic cmp_high_in,
	output logic [2:0] adc_channel_out,
	output logic adc_sample_out,
	output logic [9:0] adc_tap_out,
	output logic ref_power_out,
	output logic conv_power_out,
	output logic conversion_end_irq_out
);
	sapc_step_if step ();

	logic [7:0] mode_r;
	logic [2:0] chan_r;
	logic [1:0] pfmode_r;
	logic [7:0] thresh_r;
	logic [15:0] result_r;
	logic [15:0] rdata_r;
	logic irq_r;
	logic sample_r;
	logic cmp_meta_r;
	logic cmp_sync_r;
	logic [8:0] ref_cnt_r;
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	logic [3:0] bit_idx_r;
	sapc_pkg::sapc_state_t state_r;
	sapc_pkg::sapc_state_t state_nxt;
	logic ctrl_wr;
	logic end_ok;
	logic pf_pass;
	logic [7:0] bit_cyc;
	logic [7:0] samp_cyc;
	logic [7:0] hi_bits;

	function automatic logic is_ctrl_addr(input logic [2:0] a);
		is_ctrl_addr = (a == sapc_pkg::ADDR_MODE) || (a == sapc_pkg::ADDR_CHAN) ||
			(a == sapc_pkg::ADDR_PFMODE) || (a == sapc_pkg::ADDR_THRESH);
	endfunction

	function automatic logic [7:0] rate_cycles(input logic [7:0] mode);
		rate_cycles = sapc_pkg::RATE_BIT_CYC[mode[sapc_pkg::MODE_RATE_MSB:sapc_pkg::MODE_RATE_LSB]];
	endfunction

	assign ctrl_wr = reg_wr_in && is_ctrl_addr(reg_addr_in);
	assign bit_cyc = rate_cycles(mode_r);
	assign samp_cyc = 8'(sapc_pkg::SAMPLE_BIT_PERIODS * int'(rate_cycles(mode_r)));
	assign hi_bits = step.approx[sapc_pkg::RESULT_TOP:sapc_pkg::RESULT_CMP_LSB];
	assign end_ok = (state_r == sapc_pkg::ST_DONE) && !ctrl_wr;

	// interrupt qualification
	always_comb begin
		if (!pfmode_r[1]) begin
			pf_pass = 1'b1;
		end else if (pfmode_r[0]) begin
			pf_pass = hi_bits < thresh_r;
		end else begin
			pf_pass = hi_bits >= thresh_r;
		end
	end

	// register writes
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			mode_r <= sapc_pkg::MODE_RST;
			chan_r <= sapc_pkg::CHAN_RST;
			pfmode_r <= sapc_pkg::PFMODE_RST;
			thresh_r <= sapc_pkg::THRESH_RST;
		end else if (reg_wr_in) begin
			case (reg_addr_in)
				sapc_pkg::ADDR_MODE: begin
					mode_r <= {reg_wdata_in[sapc_pkg::MODE_START_BIT], 1'b0,
						reg_wdata_in[sapc_pkg::MODE_RATE_MSB:sapc_pkg::MODE_RATE_LSB], 2'b00,
						reg_wdata_in[sapc_pkg::MODE_REF_BIT]};
				end
				sapc_pkg::ADDR_CHAN: begin
					chan_r <= reg_wdata_in[sapc_pkg::CHAN_MSB:0];
				end
				sapc_pkg::ADDR_PFMODE: begin
					pfmode_r <= {reg_wdata_in[sapc_pkg::PF_EN_BIT], reg_wdata_in[sapc_pkg::PF_POL_BIT]};
				end
				sapc_pkg::ADDR_THRESH: begin
					thresh_r <= reg_wdata_in;
				end
				default: begin
				end
			endcase
		end
	end

	// register reads, answered in the following cycle only
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			rdata_r <= 16'h0000;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				sapc_pkg::ADDR_MODE: rdata_r <= {8'h00, mode_r};
				sapc_pkg::ADDR_CHAN: rdata_r <= {13'h0000, chan_r};
				sapc_pkg::ADDR_PFMODE: rdata_r <= {8'h00, pfmode_r, 6'h00};
				sapc_pkg::ADDR_THRESH: rdata_r <= {8'h00, thresh_r};
				sapc_pkg::ADDR_RESULT: rdata_r <= result_r;
				sapc_pkg::ADDR_STATUS: begin
					rdata_r <= {14'h0000, ref_cnt_r == sapc_pkg::REF_SETTLE_CYC, state_r != sapc_pkg::ST_IDLE};
				end
				default: rdata_r <= 16'h0000;
			endcase
		end else begin
			rdata_r <= 16'h0000;
		end
	end

	// reference settling counter, reported in status
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			ref_cnt_r <= 9'h000;
		end else if (!mode_r[sapc_pkg::MODE_REF_BIT]) begin
			ref_cnt_r <= 9'h000;
		end else if (ref_cnt_r != sapc_pkg::REF_SETTLE_CYC) begin
			ref_cnt_r <= ref_cnt_r + 9'h001;
		end
	end

	// comparator synchroniser
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			cmp_meta_r <= 1'b0;
			cmp_sync_r <= 1'b0;
		end else begin
			cmp_meta_r <= cmp_high_in;
			cmp_sync_r <= cmp_meta_r;
		end
	end

	// sequencer next state
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		if (ctrl_wr) begin
			state_nxt = sapc_pkg::ST_IDLE;
		end else begin
			case (state_r)
				sapc_pkg::ST_IDLE: begin
					if (mode_r[sapc_pkg::MODE_START_BIT]) begin
						state_nxt = sapc_pkg::ST_SAMPLE;
						cnt_nxt = samp_cyc - 8'h01;
					end
				end
				sapc_pkg::ST_SAMPLE: begin
					if (cnt_r == 8'h00) begin
						state_nxt = sapc_pkg::ST_TRIAL;
					end else begin
						cnt_nxt = cnt_r - 8'h01;
					end
				end
				sapc_pkg::ST_TRIAL: begin
					state_nxt = sapc_pkg::ST_COMPARE;
					cnt_nxt = bit_cyc - 8'h01;
				end
				sapc_pkg::ST_COMPARE: begin
					if (cnt_r != 8'h00) begin
						cnt_nxt = cnt_r - 8'h01;
					end else if (bit_idx_r == 4'h0) begin
						state_nxt = sapc_pkg::ST_DONE;
					end else begin
						state_nxt = sapc_pkg::ST_TRIAL;
					end
				end
				sapc_pkg::ST_DONE: begin
					if (mode_r[sapc_pkg::MODE_START_BIT]) begin
						state_nxt = sapc_pkg::ST_SAMPLE;
						cnt_nxt = samp_cyc - 8'h01;
					end else begin
						state_nxt = sapc_pkg::ST_IDLE;
					end
				end
				default: begin
					state_nxt = sapc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			state_r <= sapc_pkg::ST_IDLE;
			cnt_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// bit index walks from the top bit down
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			bit_idx_r <= sapc_pkg::TOP_BIT_IDX;
		end else if (state_r == sapc_pkg::ST_SAMPLE) begin
			bit_idx_r <= sapc_pkg::TOP_BIT_IDX;
		end else if (step.decide && bit_idx_r != 4'h0) begin
			bit_idx_r <= bit_idx_r - 4'h1;
		end
	end

	// sample switch closed only while sampling, open means hold
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			sample_r <= 1'b0;
		end else begin
			sample_r <= state_nxt == sapc_pkg::ST_SAMPLE;
		end
	end

	// result latch, overwritten on every accepted completion
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			result_r <= sapc_pkg::RESULT_RST;
		end else if (end_ok) begin
			result_r <= {step.approx, 6'h00};
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= end_ok && pf_pass;
		end
	end

	assign step.clear = state_r == sapc_pkg::ST_SAMPLE;
	assign step.set_trial = (state_r == sapc_pkg::ST_TRIAL) && !ctrl_wr;
	assign step.decide = (state_r == sapc_pkg::ST_COMPARE) && (cnt_r == 8'h00) && !ctrl_wr;
	assign step.cmp_high = cmp_sync_r;
	assign step.bit_idx = bit_idx_r;

	sapc_approx u_approx (
		.clk_sys_in(clk_sys_in),
		.sys_rst_in(sys_rst_in),
		.step(step)
	);

	assign reg_rdata_out = rdata_r;
	assign adc_channel_out = chan_r;
	assign adc_sample_out = sample_r;
	assign adc_tap_out = step.approx;
	assign ref_power_out = mode_r[sapc_pkg::MODE_REF_BIT];
	assign conv_power_out = mode_r[sapc_pkg::MODE_START_BIT];
	assign conversion_end_irq_out = irq_r;

	// checks
	property p_plain_irq;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		(end_ok && !pfmode_r[1]) |=> conversion_end_irq_out;
	endproperty
	a_plain_irq: assert property (p_plain_irq) else $error("plain conversion end gave no interrupt");

	property p_pf_ge;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		(state_r == sapc_pkg::ST_DONE && pfmode_r == 2'b10 && hi_bits < thresh_r) |=> !conversion_end_irq_out;
	endproperty
	a_pf_ge: assert property (p_pf_ge) else $error("interrupt below threshold with polarity 0");

	property p_pf_lt;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		(end_ok && pfmode_r == 2'b11) |=> (conversion_end_irq_out == ($past(hi_bits) < $past(thresh_r)));
	endproperty
	a_pf_lt: assert property (p_pf_lt) else $error("polarity 1 interrupt does not match compare");

	property p_result_fmt;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		end_ok |=> (result_r == {$past(step.approx), 6'h00}) && (result_r[5:0] == 6'h00);
	endproperty
	a_result_fmt: assert property (p_result_fmt) else $error("result not latched left-justified");

	property p_end_blocked;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		(state_r == sapc_pkg::ST_DONE && ctrl_wr) |=> $stable(result_r) && !conversion_end_irq_out;
	endproperty
	a_end_blocked: assert property (p_end_blocked) else $error("control write at end did not block result");

	property p_abort;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		(ctrl_wr && state_r != sapc_pkg::ST_IDLE) |=> state_r == sapc_pkg::ST_IDLE ##1
			(state_r == (mode_r[sapc_pkg::MODE_START_BIT] ? sapc_pkg::ST_SAMPLE : sapc_pkg::ST_IDLE) || $past(ctrl_wr));
	endproperty
	a_abort: assert property (p_abort) else $error("control write did not restart conversion");

	property p_stop;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		(reg_wr_in && reg_addr_in == sapc_pkg::ADDR_MODE && !reg_wdata_in[7]) |=>
			(state_r == sapc_pkg::ST_IDLE && !adc_sample_out);
	endproperty
	a_stop: assert property (p_stop) else $error("clearing start did not stop conversion");

	property p_back_to_back;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		(state_r == sapc_pkg::ST_DONE && !ctrl_wr && mode_r[7]) |=> (state_r == sapc_pkg::ST_SAMPLE && adc_sample_out);
	endproperty
	a_back_to_back: assert property (p_back_to_back) else $error("next conversion did not follow at once");

	property p_first_trial;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		(state_r == sapc_pkg::ST_TRIAL && bit_idx_r == 4'h9 && !ctrl_wr) |=> step.approx == 10'h200;
	endproperty
	a_first_trial: assert property (p_first_trial) else $error("first trial is not half reference");

	property p_hold;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		(state_r == sapc_pkg::ST_COMPARE || state_r == sapc_pkg::ST_TRIAL) |-> !adc_sample_out;
	endproperty
	a_hold: assert property (p_hold) else $error("sample switch closed during approximation");

	property p_read_first;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		(reg_rd_in && reg_addr_in == sapc_pkg::ADDR_RESULT && end_ok) |=> reg_rdata_out == $past(result_r);
	endproperty
	a_read_first: assert property (p_read_first) else $error("coinciding read saw new result");
endmodule // sapc_control
`default_nettype wire

// *** verification/sapc_analog_model.sv ***
// partner: eight analog inputs behind one sample-and-hold, and the tap comparator
// assumes levels are 10-bit codes of the reference, on the same scale as the tap
`default_nettype none
module sapc_analog_model (
	input wire logic clk_sys_in,
	input wire logic [79:0] levels_in,
	input wire logic [2:0] chan_in,
	input wire logic sample_in,
	input wire logic [9:0] tap_in,
	output logic cmp_high_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [9:0] held_r = 10'h000;
	// tracks the selected input while the switch is closed, holds once it opens
	always_ff @(posedge clk_sys_in) begin
		if (sample_in) begin
			held_r <= levels_in[chan_in * 10 +: 10];
		end
	end
	// input at or above the tap answers high
	assign cmp_high_out = (held_r >= tap_in);
endmodule // sapc_analog_model
`default_nettype wire

// *** verification/tb.sv ***
// testbench: register-port tasks, conversions on all channels, rates and power-fail cases
// assumes sapc_control with the analog model answering the comparator input
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] rdata;
	logic cmp_high;
	logic [2:0] chan;
	logic sample;
	logic [9:0] tap;
	logic ref_pw;
	logic conv_pw;
	logic irq;
	logic [7:0][9:0] levels;
	int miscompares = 0;
	int n_compared = 0;
	int n;
	logic [15:0] d;
	logic [7:0] pf_t [5] = '{8'h80, 8'h80, 8'hc0, 8'hc0, 8'h00};
	logic [9:0] lv_t [5] = '{10'h204, 10'h203, 10'h204, 10'h203, 10'h000};
	logic want_t [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};

	always #25 clk_sys_in = ~clk_sys_in;

	sapc_control dut_u (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.cmp_high_in(cmp_high), .adc_channel_out(chan), .adc_sample_out(sample), .adc_tap_out(tap),
		.ref_power_out(ref_pw), .conv_power_out(conv_pw), .conversion_end_irq_out(irq));
	sapc_analog_model model_u (.clk_sys_in(clk_sys_in), .levels_in(levels), .chan_in(chan),
		.sample_in(sample), .tap_in(tap), .cmp_high_out(cmp_high));

	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk_sys_in);
		wr <= 1'b0;
		@(posedge clk_sys_in);
	endtask

	task automatic rd_reg(input logic [2:0] a, output logic [15:0] v);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys_in);
		rd <= 1'b0;
		@(posedge clk_sys_in);
		v = rdata;
	endtask

	// counts edges until the end pulse is seen or the bound runs out
	task automatic wait_irq(input int lim, input logic want, output int cnt);
		cnt = 0;
		do begin
			@(posedge clk_sys_in);
			cnt++;
		end while (irq !== 1'b1 && cnt < lim);
		chk(16'(irq), 16'(want));
		if (want && irq !== 1'b1) begin
			close_out();
		end
	endtask

	// back-to-back conversion period for a rate code
	function automatic int per(input int r);
		int b;
		b = int'(sapc_pkg::RATE_BIT_CYC[r]);
		return sapc_pkg::SAMPLE_BIT_PERIODS * b + 10 * (b + 1) + 1;
	endfunction

	initial begin
		for (int k = 0; k < 8; k++) begin
			levels[k] = (k == 7) ? 10'h3ff : 10'(k * 146);
		end
		repeat (4) @(posedge clk_sys_in);
		sys_rst_in <= 1'b0;
		@(posedge clk_sys_in);
		// reset values, unmapped places read zero
		for (int a = 0; a < 8; a++) begin
			rd_reg(3'(a), d);
			chk(d, 16'h0000);
		end
		chk(16'({ref_pw, conv_pw, irq, sample, chan}), 16'h0000);
		chk(16'(tap), 16'h0000);
		// start without reference enable: first result thrown away, second one kept
		wr_reg(sapc_pkg::ADDR_CHAN, 8'h03);
		wr_reg(sapc_pkg::ADDR_MODE, 8'hb8);
		chk(16'({ref_pw, conv_pw}), 16'h0001);
		wait_irq(per(7) + 8, 1'b1, n);
		wait_irq(per(7) + 2, 1'b1, n);
		rd_reg(sapc_pkg::ADDR_RESULT, d);
		chk(d, {levels[3], 6'h00});
		wr_reg(sapc_pkg::ADDR_MODE, 8'h01);
		chk(16'({ref_pw, conv_pw}), 16'h0002);
		repeat (sapc_pkg::REF_SETTLE_CYC_I) @(posedge clk_sys_in);
		rd_reg(sapc_pkg::ADDR_STATUS, d);
		chk(d, 16'h0002);
		wr_reg(sapc_pkg::ADDR_MODE, 8'hb9);
		rd_reg(sapc_pkg::ADDR_STATUS, d);
		chk(d, 16'h0003);
		// every channel, each change followed by one conversion time
		for (int ch = 0; ch < 8; ch++) begin
			wr_reg(sapc_pkg::ADDR_CHAN, 8'(ch));
			chk(16'(chan), 16'(ch));
			wait_irq(per(7) + 4, 1'b1, n);
			chk(16'(n >= per(7) - 1 && n <= per(7) + 3), 16'h0001);
			rd_reg(sapc_pkg::ADDR_RESULT, d);
			chk(d, {levels[ch], 6'h00});
		end
		// read at end of conversion returns the old result; then overwritten
		wait_irq(per(7) + 2, 1'b1, n);
		levels[7] <= 10'h100;
		repeat (69) @(posedge clk_sys_in);
		rd_reg(sapc_pkg::ADDR_RESULT, d);
		chk(d, 16'hffc0);
		rd_reg(sapc_pkg::ADDR_RESULT, d);
		chk(d, 16'h4000);
		// channel write at end of conversion drops that result and its pulse
		wait_irq(per(7) + 2, 1'b1, n);
		levels[7] <= 10'h2aa;
		repeat (69) @(posedge clk_sys_in);
		wr_reg(sapc_pkg::ADDR_CHAN, 8'h07);
		chk(16'(irq), 16'h0000);
		rd_reg(sapc_pkg::ADDR_RESULT, d);
		chk(d, 16'h4000);
		wait_irq(per(7) + 4, 1'b1, n);
		rd_reg(sapc_pkg::ADDR_RESULT, d);
		chk(d, 16'haa80);
		// power-fail compare on the top eight bits, both polarities, then plain mode
		for (int i = 0; i < 5; i++) begin
			wr_reg(sapc_pkg::ADDR_MODE, 8'h39);
			chk(16'({ref_pw, conv_pw}), 16'h0002);
			wait_irq(per(7) + 4, 1'b0, n);
			levels[7] <= lv_t[i];
			wr_reg(sapc_pkg::ADDR_PFMODE, pf_t[i]);
			wr_reg(sapc_pkg::ADDR_THRESH, 8'h81);
			wr_reg(sapc_pkg::ADDR_MODE, 8'hb9);
			wait_irq(2 * per(7) + 8, want_t[i], n);
			rd_reg(sapc_pkg::ADDR_RESULT, d);
			chk(d, {lv_t[i], 6'h00});
		end
		// every rate code sets the back-to-back period
		for (int r = 0; r < 8; r++) begin
			wr_reg(sapc_pkg::ADDR_MODE, 8'h01 | 8'(r << 3));
			wr_reg(sapc_pkg::ADDR_MODE, 8'h81 | 8'(r << 3));
			rd_reg(sapc_pkg::ADDR_MODE, d);
			chk(d, 16'(8'h81 | 8'(r << 3)));
			wait_irq(per(r) + 8, 1'b1, n);
			wait_irq(per(r) + 2, 1'b1, n);
			chk(16'(n), 16'(per(r)));
		end
		close_out();
	end
endmodule // tb
`default_nettype wire
